// File: verilog/dacc_control.sv
// Register access over APB was chosen for this implementation.
`default_nettype none
module dacc_control
  import dacc_pkg::*;
#(
  parameter int STARTUP_CYCLES = DACC_STARTUP_CYC
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // system sleep state
  input  wire logic        standby_sleep,
  input  wire logic        powerdown_sleep,
  input  wire logic        per_clk_avail,
  input  wire logic        debug_halt,
  // analog core
  output logic             core_power,
  output logic             buffer_power,
  output logic             internal_out_valid,
  output logic      [7:0]  sample_code,
  output logic             conv_start
);
  logic [7:0]  dac_control;
  logic [7:0]  dac_sample_value;
  logic [7:0]  next_dac_control;
  logic [7:0]  next_dac_sample_value;
  dacc_state_t state;
  dacc_state_t next_state;
  logic        pending;
  logic        next_pending;
  logic        next_conv_start;
  logic        next_core_power;
  logic        next_buffer_power;
  logic        next_internal_out_valid;
  logic [7:0]  next_sample_code;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        wr_control;
  logic        wr_sample;
  logic        rd_hit;
  logic        access;
  logic        ena;
  logic        sleeping;
  logic        timer_start;
  logic        timer_abort;
  logic        warm_done;

  dacc_apb_slave u_bus (
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .wr_control (wr_control),
    .wr_sample  (wr_sample),
    .rd_hit     (rd_hit),
    .access     (access)
  );

  dacc_startup_timer #(
    .COUNT (STARTUP_CYCLES)
  ) u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .start   (timer_start),
    .abort   (timer_abort),
    .done    (warm_done)
  );

  // register file; debug_halt deliberately unused so halting changes nothing
  always_comb begin
    next_dac_control      = dac_control;
    next_dac_sample_value = dac_sample_value;
    next_pready           = 1'b0;
    next_pslverr          = 1'b0;
    next_prdata           = prdata;
    if (wr_control && !pready) begin
      next_dac_control = pwdata[7:0] & DACC_CONTROL_MASK;
    end
    if (wr_sample && !pready) begin
      next_dac_sample_value = pwdata[7:0];
    end
    // one wait state: pready rises the cycle after the access phase begins
    if (access && !pready) begin
      next_pready  = 1'b1;
      next_pslverr = !rd_hit;
      next_prdata  = 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          DACC_CONTROL_OFFSET: next_prdata = {24'h00_0000, dac_control};
          DACC_SAMPLE_OFFSET:  next_prdata = {24'h00_0000, dac_sample_value};
          DACC_STATUS_OFFSET:  next_prdata = {29'h0000_0000, state};
          default:             next_prdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_control      <= DACC_CONTROL_RESET;
      dac_sample_value <= DACC_SAMPLE_RESET;
      prdata           <= 32'h0000_0000;
      pready           <= 1'b0;
      pslverr          <= 1'b0;
    end else if (clk_en) begin
      dac_control      <= next_dac_control;
      dac_sample_value <= next_dac_sample_value;
      prdata           <= next_prdata;
      pready           <= next_pready;
      pslverr          <= next_pslverr;
    end
  end

  // converter power sequencing
  always_comb begin
    ena      = dac_control[DACC_ENABLE_BIT];
    sleeping = powerdown_sleep
               || (standby_sleep && !(dac_control[DACC_RUN_STBY_BIT] && per_clk_avail));
    next_state              = state;
    next_pending            = pending;
    next_conv_start         = 1'b0;
    next_sample_code        = sample_code;
    timer_start             = 1'b0;
    timer_abort             = 1'b0;
    // a sample write during warm-up is held and converted once ready
    if (wr_sample && !pready) begin
      next_pending = 1'b1;
    end
    case (state)
      DACC_OFF: begin
        if (ena && !sleeping) begin
          timer_start  = 1'b1;
          next_pending = 1'b1;
          next_state   = DACC_WARM;
        end
      end
      DACC_WARM: begin
        if (!ena || sleeping) begin
          timer_abort = 1'b1;
          next_state  = DACC_OFF;
        end else if (warm_done) begin
          next_state = DACC_RUN;
        end
      end
      DACC_RUN: begin
        if (!ena || sleeping) begin
          next_state = DACC_OFF;
        end else if (pending && !(wr_sample && !pready)) begin
          // a write landing now supersedes the held code: one strobe, next cycle
          next_pending     = 1'b0;
          next_conv_start  = 1'b1;
          next_sample_code = dac_sample_value;
        end
      end
      default: begin
        next_state = DACC_OFF;
      end
    endcase
    next_core_power         = (next_state != DACC_OFF);
    next_buffer_power       = next_core_power && dac_control[DACC_PIN_OUT_BIT];
    next_internal_out_valid = (next_state == DACC_RUN);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state              <= DACC_OFF;
      pending            <= 1'b0;
      conv_start         <= 1'b0;
      sample_code        <= DACC_SAMPLE_RESET;
      core_power         <= 1'b0;
      buffer_power       <= 1'b0;
      internal_out_valid <= 1'b0;
    end else if (clk_en) begin
      state              <= next_state;
      pending            <= next_pending;
      conv_start         <= next_conv_start;
      sample_code        <= next_sample_code;
      core_power         <= next_core_power;
      buffer_power       <= next_buffer_power;
      internal_out_valid <= next_internal_out_valid;
    end
  end
endmodule // dacc_control
`default_nettype wire

// File: verilog/dacc_pkg.sv
`default_nettype none
package dacc_pkg;
  // register indices; each register takes one aligned 32-bit word
  localparam int DACC_CONTROL_INDEX = 0;
  localparam int DACC_SAMPLE_INDEX  = 1;
  localparam int DACC_STATUS_INDEX  = 2;
  // byte addresses on the bus are four times the index
  localparam logic [11:0] DACC_CONTROL_OFFSET = 12'(DACC_CONTROL_INDEX * 4);
  localparam logic [11:0] DACC_SAMPLE_OFFSET  = 12'(DACC_SAMPLE_INDEX * 4);
  localparam logic [11:0] DACC_STATUS_OFFSET  = 12'(DACC_STATUS_INDEX * 4);
  // control field positions
  localparam int DACC_ENABLE_BIT   = 0;
  localparam int DACC_PIN_OUT_BIT  = 6;
  localparam int DACC_RUN_STBY_BIT = 7;
  localparam logic [7:0] DACC_CONTROL_MASK  = 8'hc1;
  localparam logic [7:0] DACC_CONTROL_RESET = 8'h00;
  localparam logic [7:0] DACC_SAMPLE_RESET  = 8'h00;
  // start-up time after power-up of the core
  localparam int DACC_CLK_MHZ       = 50;
  localparam int DACC_STARTUP_NS    = 1000;
  localparam int DACC_STARTUP_CYC   = (DACC_STARTUP_NS * DACC_CLK_MHZ + 999) / 1000;
  localparam int DACC_STARTUP_W     = 8;
  typedef enum logic [2:0] {
    DACC_OFF   = 3'b001,
    DACC_WARM  = 3'b010,
    DACC_RUN   = 3'b100
  } dacc_state_t;
endpackage : dacc_pkg
`default_nettype wire

// File: verilog/dacc_startup_timer.sv
`default_nettype none
module dacc_startup_timer
  import dacc_pkg::*;
#(
  parameter int COUNT = DACC_STARTUP_CYC
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  // control
  input  wire logic start,
  input  wire logic abort,
  output logic      done
);
  logic [DACC_STARTUP_W-1:0] count;
  logic [DACC_STARTUP_W-1:0] next_count;
  logic                      next_done;

  always_comb begin
    next_count = count;
    next_done  = 1'b0;
    if (abort) begin
      next_count = '0;
    end else if (start) begin
      next_count = DACC_STARTUP_W'(COUNT);
    end else if (count != '0) begin
      next_count = count - 1'b1;
      next_done  = (count == DACC_STARTUP_W'(1));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
      done  <= 1'b0;
    end else if (clk_en) begin
      count <= next_count;
      done  <= next_done;
    end
  end
endmodule // dacc_startup_timer
`default_nettype wire

// File: verilog/dacc_apb_slave.sv
`default_nettype none
module dacc_apb_slave
  import dacc_pkg::*;
(
  // apb request
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  // decoded strokes
  output logic             wr_control,
  output logic             wr_sample,
  output logic             rd_hit,
  output logic             access
);
  logic mapped;

  always_comb begin
    access     = psel && penable;
    mapped     = (paddr == DACC_CONTROL_OFFSET) || (paddr == DACC_SAMPLE_OFFSET)
                 || (paddr == DACC_STATUS_OFFSET);
    wr_control = access && pwrite && (paddr == DACC_CONTROL_OFFSET);
    wr_sample  = access && pwrite && (paddr == DACC_SAMPLE_OFFSET);
    rd_hit     = mapped;
  end
endmodule // dacc_apb_slave
`default_nettype wire

// File: testbench/dacc_control_assertions.sv
`default_nettype none
module dacc_control_assertions
  import dacc_pkg::*;
(
  // bus
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // sleep and core
  input wire logic        standby_sleep,
  input wire logic        powerdown_sleep,
  input wire logic        core_power,
  input wire logic        buffer_power,
  input wire logic        internal_out_valid,
  input wire logic [7:0]  sample_code,
  input wire logic        conv_start
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic awake;
  assign awake = !standby_sleep && !powerdown_sleep;
  sequence s_acc; psel && penable && !pready; endsequence
  sequence s_wctl; s_acc ##0 pwrite && paddr == DACC_CONTROL_OFFSET && awake; endsequence
  sequence s_wdat; s_acc ##0 pwrite && paddr == DACC_SAMPLE_OFFSET && awake; endsequence
  property p_ready; s_acc |=> pready; endproperty
  property p_err; s_acc ##0 paddr > 12'h008 |=> pslverr; endproperty
  property p_on; s_wctl ##0 pwdata[0] |-> ##[1:2] core_power; endproperty
  property p_off; s_wctl ##0 !pwdata[0] |-> ##[1:2] !core_power; endproperty
  property p_run;
    s_wdat ##0 internal_out_valid |-> ##2 conv_start && sample_code == $past(pwdata[7:0], 2);
  endproperty
  property p_pd; powerdown_sleep [*3] |-> !core_power && !buffer_power; endproperty
  property p_buf; buffer_power |-> core_power; endproperty
  property p_int; internal_out_valid |-> core_power; endproperty
  property p_pulse; conv_start |=> !conv_start; endproperty
  // the core needs its settle time, so no start on the power-up edge
  property p_warm; $rose(core_power) |-> !conv_start [*2]; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  a_err: assert property (p_err) else $error("no slave error");
  a_on: assert property (p_on) else $error("core not on");
  a_off: assert property (p_off) else $error("core not off");
  a_run: assert property (p_run) else $error("no start on sample write");
  a_pd: assert property (p_pd) else $error("powered in power-down");
  a_buf: assert property (p_buf) else $error("buffer without core");
  a_int: assert property (p_int) else $error("output without core");
  a_pulse: assert property (p_pulse) else $error("start too long");
  a_warm: assert property (p_warm) else $error("start during warm-up");
endmodule // dacc_control_assertions
bind dacc_control dacc_control_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .standby_sleep, .powerdown_sleep, .core_power,
  .buffer_power, .internal_out_valid, .sample_code, .conv_start);
`default_nettype wire

// File: testbench/dacc_control_bench.sv
`default_nettype none
module dacc_control_bench
  import dacc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, err;
  logic standby_sleep, powerdown_sleep, per_clk_avail, debug_halt;
  logic core_power, buffer_power, internal_out_valid, conv_start;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  sample_code;
  int bad_count = 0;
  int cmp_count = 0;
  int starts = 0;
  dacc_control #(.STARTUP_CYCLES(3)) dut (.pclk, .presetn, .clk_en, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .standby_sleep, .powerdown_sleep,
    .per_clk_avail, .debug_halt, .core_power, .buffer_power, .internal_out_valid,
    .sample_code, .conv_start);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) if (conv_start === 1'b1) starts <= starts + 1;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // leading edge keeps the release and the next setup in separate steps
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic give_verdict;
    $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge pclk);
    bad_count++;
    give_verdict();
  end
  initial begin
    {presetn, clk_en, psel, penable, pwrite} = 5'b01000;
    {standby_sleep, powerdown_sleep, per_clk_avail, debug_halt} = 4'b0010;
    paddr  = 12'h000;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    xfer(0, DACC_CONTROL_OFFSET, 0); chk(rd, 0);
    xfer(0, DACC_SAMPLE_OFFSET, 0); chk(rd, 0);
    xfer(1, DACC_SAMPLE_OFFSET, 32'h5a);
    xfer(0, DACC_SAMPLE_OFFSET, 0); chk(rd, 32'h5a);
    cyc(4); chk(starts, 0);
    xfer(1, DACC_CONTROL_OFFSET, 32'h3e);
    xfer(0, DACC_CONTROL_OFFSET, 0); chk(rd, 0);
    debug_halt <= 1'b1;
    xfer(1, DACC_CONTROL_OFFSET, 32'h41); cyc(10);
    chk(starts, 1);
    chk(sample_code, 32'h5a);
    chk({core_power, buffer_power, internal_out_valid}, 3'b111);
    xfer(0, DACC_STATUS_OFFSET, 0); chk(rd, 32'h4);
    xfer(1, DACC_SAMPLE_OFFSET, 32'h11);
    xfer(1, DACC_SAMPLE_OFFSET, 32'h22); cyc(3);
    chk({starts[7:0], sample_code}, 16'h0322);
    xfer(1, DACC_CONTROL_OFFSET, 32'h01); cyc(3);
    chk({buffer_power, internal_out_valid}, 2'b01);
    standby_sleep <= 1'b1; cyc(4); chk(core_power, 0);
    standby_sleep <= 1'b0; clk_en <= 1'b0; cyc(10); chk(starts, 3);
    clk_en <= 1'b1; cyc(10); chk(starts, 4);
    xfer(1, DACC_CONTROL_OFFSET, 32'hc1);
    standby_sleep <= 1'b1; cyc(4); chk({core_power, buffer_power}, 2'b11);
    per_clk_avail <= 1'b0; cyc(4); chk(core_power, 0);
    {standby_sleep, per_clk_avail, powerdown_sleep} <= 3'b011;
    cyc(4); chk({core_power, buffer_power}, 2'b00);
    powerdown_sleep <= 1'b0; cyc(10);
    xfer(0, 12'h00c, 0); chk({err, rd[30:0]}, 32'h80000000);
    xfer(1, DACC_CONTROL_OFFSET, 0); cyc(3); chk(core_power, 0);
    give_verdict();
  end
endmodule // dacc_control_bench
`default_nettype wire
